// ---- hdl/cmp_mode_ctrl.sv ----
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module cmp_mode_ctrl
	import cmp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cpu_wait,
	input wire logic cpu_stop,
	input wire logic special_mode,
	input wire logic bus_rx_pin,
	output logic bus_tx_pin,
	input wire logic mac_tx_bit,
	output logic mac_rx_bit,
	input wire logic bit_tick,
	input wire logic mac_receiving,
	input wire logic bus_off,
	input wire logic rx_bg_full,
	input wire logic [2:0] tx_sent,
	input wire logic [2:0] tx_aborted,
	output logic proto_run,
	output logic proto_abort,
	output logic tx_allow,
	output logic [2:0] abort_go,
	output logic rx_fg_load,
	output logic busoff_count_en,
	output logic wake_event,
	output logic [15:0] bit_timing,
	output logic [31:0] filter_cfg
);

	typedef struct packed {
		logic init_req;
		logic slp_req;
		logic wake_en;
		logic stop_wait;
		logic rx_full;
		logic wake_filt;
		logic listen;
		logic mod_en;
		logic en_locked;
		logic [15:0] btime;
		logic [31:0] filt;
		logic [2:0] txe;
		logic [2:0] abrq;
		logic [2:0] abak;
		logic ireq_s1;
		logic ireq_s2;
		logic can_init;
		logic iack_s1;
		logic iack_s2;
		logic sreq_s1;
		logic sreq_s2;
		logic sack_s1;
		logic sack_s2;
		cmp_state_type state;
		logic wake_lat;
		logic was_sleep;
		logic [7:0] cnt;
		logic [7:0] fcnt;
		logic [3:0] rcnt;
		logic aw_have;
		logic w_have;
		logic [7:0] waddr;
		logic [31:0] wdat;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic tx_pin;
		logic mac_rx;
		logic run;
		logic abort;
		logic txa;
		logic [2:0] abgo;
		logic fg_load;
		logic bo_cnt;
		logic wake;
		logic pd_woke;
	} cmp_regs_type;

	cmp_regs_type q;
	cmp_regs_type n;
	logic rst_s1_q;
	logic rst_core_n_q;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[8*i +: 8] = val[8*i +: 8];
		end
		return r;
	endfunction : merge

	function automatic logic active(input cmp_state_type s);
		return (s == ST_RUN) || (s == ST_SLEEP_WAIT);
	endfunction : active

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1_q <= 1'b0;
			rst_core_n_q <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_core_n_q <= rst_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		logic pd_req;
		logic dom;
		logic wake_det;
		logic [31:0] wv;
		logic cfg_ok;
		logic done_all;
		pd_req = 1'b0;
		dom = 1'b0;
		wake_det = 1'b0;
		wv = 32'h00000000;
		cfg_ok = 1'b0;
		done_all = 1'b0;
		n = q;
		n.wake = 1'b0;
		n.fg_load = 1'b0;
		if (q.state != ST_POWER_DOWN)
			n.pd_woke = 1'b0;

		// stop always once enabled, wait only with stop bit
		// plain wait leaves the block running
		pd_req = q.mod_en && (cpu_stop || (cpu_wait && q.stop_wait));

		// dominant must persist when filter selected
		dom = !bus_rx_pin;
		n.fcnt = (dom && q.fcnt != WAKE_FILT_CYC) ? q.fcnt + 8'h01 : (dom ? q.fcnt : 8'h00);
		wake_det = q.wake_filt ? (dom && q.fcnt == WAKE_FILT_CYC) : dom;

		// request into protocol side, acknowledges back
		n.ireq_s1 = q.init_req;
		n.ireq_s2 = q.ireq_s1;
		n.can_init = q.ireq_s2;
		n.iack_s1 = q.can_init && (q.state == ST_INIT);
		n.iack_s2 = q.iack_s1;
		n.sreq_s1 = q.slp_req;
		n.sreq_s2 = q.sreq_s1;
		n.sack_s1 = (q.state == ST_SLEEP);
		n.sack_s2 = q.sack_s1;

		// wake enable only counts as set at sleep entry
		if (q.state != ST_SLEEP && q.state != ST_POWER_DOWN)
			n.wake_lat = q.wake_en;

		done_all = (q.txe == RST_TX_EMPTY) && !mac_receiving;

		// protocol-side mode sequencing
		case (q.state)
			ST_DISABLED:
			begin
				if (q.mod_en)
					n.state = ST_INIT;
			end
			ST_INIT:
			begin
				if (!q.can_init)
				begin
					n.state = ST_RESYNC;
					n.rcnt = 4'h0;
				end
			end
			ST_RUN:
			begin
				// sleep at once only when idle
				if (q.sreq_s2)
					n.state = done_all ? ST_SLEEP : ST_SLEEP_WAIT;
			end
			ST_SLEEP_WAIT:
			begin
				// finish scheduled tx and current rx first
				if (!q.sreq_s2)
					n.state = ST_RUN;
				else if (done_all)
					n.state = ST_SLEEP;
			end
			ST_SLEEP:
			begin
				// leave on request clear or enabled activity
				if (!q.sreq_s2)
				begin
					n.state = ST_RESYNC;
					n.rcnt = 4'h0;
				end
				else if (q.wake_lat && wake_det)
				begin
					n.state = ST_RESYNC;
					n.rcnt = 4'h0;
					n.slp_req = 1'b0;
					n.wake = 1'b1;
				end
			end
			ST_POWER_DOWN:
			begin
				// one pulse per stay, a held dominant would repeat it
				if (q.was_sleep && q.wake_lat && wake_det && !q.pd_woke)
				begin
					n.wake = 1'b1;
					n.pd_woke = 1'b1;
				end
				if (!pd_req)
				begin
					// fixed recovery delay unless slept before
					n.state = q.was_sleep ? ST_SLEEP : ST_RECOVERY;
					n.cnt = 8'h00;
				end
			end
			ST_RECOVERY:
			begin
				n.cnt = q.cnt + 8'h01;
				if (q.cnt == RECOVERY_CYC - 8'h01)
				begin
					n.state = ST_RESYNC;
					n.rcnt = 4'h0;
				end
			end
			ST_RESYNC:
			begin
				// eleven recessive bits before joining the bus
				if (bit_tick)
					n.rcnt = bus_rx_pin ? q.rcnt + 4'h1 : 4'h0;
				if (q.rcnt == IDLE_BITS)
					n.state = ST_RUN;
			end
			default:
			begin
				n.state = ST_DISABLED;
			end
		endcase

		// disable beats power down, power down beats init, init beats everything else
		if (!q.mod_en)
			n.state = ST_DISABLED;
		else if (pd_req && q.state != ST_POWER_DOWN && q.state != ST_DISABLED)
		begin
			n.state = ST_POWER_DOWN;
			n.was_sleep = (q.state == ST_SLEEP);
		end
		// init request aborts any mode except power down and disabled at once
		else if (q.can_init && q.state != ST_POWER_DOWN && q.state != ST_DISABLED)
			n.state = ST_INIT;

		// register bus: write side
		cfg_ok = special_mode || q.iack_s2;
		if (s_axi_awvalid && q.awready)
		begin
			n.aw_have = 1'b1;
			n.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready)
		begin
			n.w_have = 1'b1;
			n.wdat = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			n.bvalid = 1'b0;
		if (q.aw_have && q.w_have && !q.bvalid)
		begin
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			if (q.state == ST_POWER_DOWN)
				n.bresp = RESP_SLVERR;
			else
				case (q.waddr)
					OFS_CTRL0:
					begin
						wv = merge({24'h000000, q.rx_full, 1'b0, q.stop_wait, 2'h0, q.wake_en,
							q.slp_req, q.init_req}, q.wdat, q.wstrb);
						if (wv[C0_INIT_REQ] || q.iack_s2)
							n.init_req = wv[C0_INIT_REQ];
						if (wv[C0_SLEEP_REQ] || q.sack_s2)
							n.slp_req = wv[C0_SLEEP_REQ];
						n.wake_en = wv[C0_WAKE_EN];
						n.stop_wait = wv[C0_STOP_WAIT];
						if (q.wstrb[0] && q.wdat[C0_RX_FULL])
							n.rx_full = 1'b0;
					end
					OFS_CTRL1:
					begin
						wv = merge({24'h000000, q.mod_en, 2'h0, q.listen, 1'b0, q.wake_filt,
							2'h0}, q.wdat, q.wstrb);
						if (cfg_ok)
						begin
							n.wake_filt = wv[C1_WAKE_FILT];
							n.listen = wv[C1_LISTEN];
						end
						if (q.wstrb[0] && (special_mode || !q.en_locked))
						begin
							n.mod_en = wv[C1_MOD_EN];
							n.en_locked = !special_mode;
							if (wv[C1_MOD_EN] && !q.mod_en)
								n.init_req = RST_INIT_REQ;
						end
					end
					// timing and filters writable only in init or special mode
					OFS_BTIME:
					begin
						if (cfg_ok)
							n.btime = 16'(merge({16'h0000, q.btime}, q.wdat, q.wstrb));
					end
					OFS_FILT:
					begin
						if (cfg_ok)
							n.filt = merge(q.filt, q.wdat, q.wstrb);
					end
					OFS_TXF:
					begin
						wv = q.wstrb[0] ? q.wdat : 32'h00000000;
						// empty flags clearable even while asleep
						n.txe = q.txe & ~wv[TF_EMPTY +: 3];
						n.abrq = q.abrq | (wv[TF_ABORT_REQ +: 3] & ~q.txe);
					end
					OFS_STAT:
					begin
					end
					default:
					begin
						n.bresp = RESP_SLVERR;
					end
				endcase
		end

		// hardware events win over software clears
		n.txe = n.txe | tx_sent | tx_aborted;
		n.abak = (q.abak & ~(q.txe & ~n.txe)) | tx_aborted;
		n.abrq = n.abrq & ~(tx_sent | tx_aborted);

		if (active(q.state) && rx_bg_full && !q.rx_full && !q.fg_load)
		begin
			n.fg_load = 1'b1;
			n.rx_full = 1'b1;
		end

		// init mode forces status and control defaults
		if (q.state == ST_INIT)
		begin
			n.txe = RST_TX_EMPTY;
			n.abrq = 3'h0;
			n.abak = 3'h0;
			n.rx_full = 1'b0;
			n.slp_req = 1'b0;
		end

		// register bus: read side
		if (s_axi_rvalid && s_axi_rready)
			n.rvalid = 1'b0;
		if (s_axi_arvalid && q.arready)
		begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			n.rdata = 32'h00000000;
			if (q.state == ST_POWER_DOWN)
				n.rresp = RESP_SLVERR;
			else
				// map readable in every other mode
				case (s_axi_araddr)
					OFS_CTRL0:
					begin
						n.rdata[C0_INIT_REQ] = q.init_req;
						n.rdata[C0_SLEEP_REQ] = q.slp_req;
						n.rdata[C0_WAKE_EN] = q.wake_en;
						n.rdata[C0_STOP_WAIT] = q.stop_wait;
						n.rdata[C0_RX_FULL] = q.rx_full;
					end
					OFS_CTRL1:
					begin
						n.rdata[C1_INIT_ACK] = q.iack_s2;
						n.rdata[C1_SLEEP_ACK] = q.sack_s2;
						n.rdata[C1_WAKE_FILT] = q.wake_filt;
						n.rdata[C1_LISTEN] = q.listen;
						n.rdata[C1_MOD_EN] = q.mod_en;
					end
					OFS_BTIME:
						n.rdata = {16'h0000, q.btime};
					OFS_FILT:
						n.rdata = q.filt;
					OFS_TXF:
					begin
						n.rdata[TF_EMPTY +: 3] = q.txe;
						n.rdata[TF_ABORT_REQ +: 3] = q.abrq;
						n.rdata[TF_ABORT_ACK +: 3] = q.abak;
					end
					OFS_STAT:
						n.rdata[7:0] = q.state;
					default:
						n.rresp = RESP_SLVERR;
				endcase
		end
		n.awready = !n.aw_have && !n.bvalid;
		n.wready = !n.w_have && !n.bvalid;
		n.arready = !n.rvalid;

		// pin and protocol-engine controls
		// tx recessive unless active and talking
		n.tx_pin = (active(n.state) && !q.listen) ? mac_tx_bit : 1'b1;
		// masked receive input while locked asleep
		if ((n.state == ST_SLEEP || n.state == ST_POWER_DOWN) && !n.wake_lat)
			n.mac_rx = 1'b1;
		// own dominant bits seen internally only
		else if (q.listen)
			n.mac_rx = bus_rx_pin && mac_tx_bit;
		else
			n.mac_rx = bus_rx_pin;
		// protocol clocks stop in sleep, init, power down
		n.run = active(n.state) || (n.state == ST_RESYNC);
		n.abort = (n.state == ST_INIT) || (n.state == ST_POWER_DOWN) ||
			(n.state == ST_DISABLED);
		n.txa = active(n.state) && !q.listen && (n.txe != RST_TX_EMPTY);
		n.abgo = active(n.state) ? (n.abrq & ~n.txe) : 3'h0;
		// bus-off count pauses asleep, resumes after
		n.bo_cnt = bus_off && n.run;
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_core_n_q)
	begin
		if (!rst_core_n_q)
		begin
			q <= '0;
			// out of reset disabled, enable clear
			q.state <= ST_DISABLED;
			q.init_req <= RST_INIT_REQ;
			q.txe <= RST_TX_EMPTY;
			q.btime <= RST_BTIME;
			q.filt <= RST_FILT;
			q.tx_pin <= 1'b1;
			q.mac_rx <= 1'b1;
			q.abort <= 1'b1;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
		end
		else
			q <= n;
	end

	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign bus_tx_pin = q.tx_pin;
	assign mac_rx_bit = q.mac_rx;
	assign proto_run = q.run;
	assign proto_abort = q.abort;
	assign tx_allow = q.txa;
	assign abort_go = q.abgo;
	assign rx_fg_load = q.fg_load;
	assign busoff_count_en = q.bo_cnt;
	assign wake_event = q.wake;
	assign bit_timing = q.btime;
	assign filter_cfg = q.filt;

endmodule : cmp_mode_ctrl
`default_nettype wire

// ---- hdl/cmp_pkg.sv ----
package cmp_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL0 = 8'h00;
	localparam logic [7:0] OFS_CTRL1 = 8'h04;
	localparam logic [7:0] OFS_BTIME = 8'h08;
	localparam logic [7:0] OFS_FILT = 8'h0c;
	localparam logic [7:0] OFS_TXF = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;
	// control_reg_0 fields
	localparam int C0_INIT_REQ = 0;
	localparam int C0_SLEEP_REQ = 1;
	localparam int C0_WAKE_EN = 2;
	localparam int C0_STOP_WAIT = 5;
	localparam int C0_RX_FULL = 7;
	// control_reg_1 fields
	localparam int C1_INIT_ACK = 0;
	localparam int C1_SLEEP_ACK = 1;
	localparam int C1_WAKE_FILT = 2;
	localparam int C1_LISTEN = 4;
	localparam int C1_MOD_EN = 7;
	// tx flag register fields
	localparam int TF_EMPTY = 0;
	localparam int TF_ABORT_REQ = 4;
	localparam int TF_ABORT_ACK = 8;
	// reset values
	localparam logic RST_INIT_REQ = 1'b1;
	localparam logic [2:0] RST_TX_EMPTY = 3'h7;
	localparam logic [15:0] RST_BTIME = 16'h0000;
	localparam logic [31:0] RST_FILT = 32'h00000000;
	// timing
	localparam int CLK_NS = 20;
	localparam int WAKE_FILT_NS = 2000;
	localparam int RECOVERY_NS = 2000;
	localparam logic [7:0] WAKE_FILT_CYC = 8'((WAKE_FILT_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] RECOVERY_CYC = 8'((RECOVERY_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] IDLE_BITS = 4'hb;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [7:0] {
		ST_DISABLED = 8'h01,
		ST_INIT = 8'h02,
		ST_RUN = 8'h04,
		ST_SLEEP_WAIT = 8'h08,
		ST_SLEEP = 8'h10,
		ST_POWER_DOWN = 8'h20,
		ST_RECOVERY = 8'h40,
		ST_RESYNC = 8'h80
	} cmp_state_type;
endpackage : cmp_pkg

// ---- verification/can_mode_power_control_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module can_mode_power_control_test;
	import cmp_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic cpu_wait = 1'b0, cpu_stop = 1'b0, mac_tx_bit = 1'b1, bit_tick = 1'b0;
	logic special_mode = 1'b0;
	logic mac_receiving = 1'b0, bus_off = 1'b0, rx_bg_full = 1'b0;
	logic [2:0] tx_aborted = 3'h0, tx_sent = 3'h0, abort_go;
	logic bus_rx_pin, bus_tx_pin, mac_rx_bit, proto_run, proto_abort, tx_allow;
	logic rx_fg_load, busoff_count_en, wake_event;
	logic [15:0] bit_timing;
	logic [31:0] filter_cfg, d, v;
	logic [1:0] r;
	int bad_count = 0, checks = 0, cyc = 0, tk = 0;
	always #10 clk = ~clk;
	cmp_mode_ctrl dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_wait, .cpu_stop,
		.special_mode, .bus_rx_pin, .bus_tx_pin, .mac_tx_bit, .mac_rx_bit,
		.bit_tick, .mac_receiving, .bus_off, .rx_bg_full, .tx_sent, .tx_aborted,
		.proto_run, .proto_abort, .tx_allow, .abort_go, .rx_fg_load, .busoff_count_en,
		.wake_event, .bit_timing, .filter_cfg);
	cmp_bus_node node (.clk, .tx(bus_tx_pin), .rx(bus_rx_pin));
	////////////////////////////////////////////////////////////////
	task finish_test;
		if (bad_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= x;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		int n;
		n = 0;
		do
		begin
			rd(a);
			n++;
		end
		while ((d & m) !== e && n < 100);
		chk("poll", e, d & m);
	endtask : poll
	////////////////////////////////////////////////////////////////
	// hang guard: whole run is under a thousand cycles, limit at 20000
	always @(posedge clk)
	begin
		cyc++;
		tk <= (tk + 1) % 4;
		bit_tick <= (tk == 3);
		if (cyc == 20000)
		begin
			bad_count++;
			finish_test;
		end
	end
	initial
	begin
		void'($urandom(32'he733));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(OFS_STAT);
		chk("state", 32'h1, d);
		rd(8'h18);
		chk("resp", {30'h0, RESP_SLVERR}, {30'h0, r});
		rd(OFS_CTRL0);
		chk("init_req", 32'h1, d & 32'h1);
		// clear tried while still unacknowledged
		wr(OFS_CTRL0, 32'h0);
		rd(OFS_CTRL0);
		chk("init_req", 32'h1, d & 32'h1);
		wr(OFS_CTRL1, 32'h80);
		rd(OFS_STAT);
		chk("state", 32'h2, d);
		chk("tx", 32'h1, {31'h0, bus_tx_pin & proto_abort});
		poll(OFS_CTRL1, 32'h1, 32'h1);
		wr(OFS_CTRL1, 32'h94);
		v = $urandom;
		wr(OFS_BTIME, v);
		rd(OFS_BTIME);
		chk("btime", {16'h0, v[15:0]}, d);
		chk("btime_out", {16'h0, v[15:0]}, {16'h0, bit_timing});
		rd(OFS_CTRL1);
		chk("ctrl1", 32'h95, d);
		wr(OFS_CTRL0, 32'h0);
		poll(OFS_STAT, 32'hff, 32'h4);
		bus_off <= 1'b1;
		rx_bg_full <= 1'b1;
		// scheduled, so only listening keeps tx_allow low
		wr(OFS_TXF, 32'h01);
		mac_tx_bit <= 1'b0;
		repeat (3) @(posedge clk);
		chk("listen", 32'h2, {30'h0, bus_tx_pin, mac_rx_bit | tx_allow});
		mac_tx_bit <= 1'b1;
		// abort only counts for an already scheduled buffer
		wr(OFS_TXF, 32'h10);
		repeat (3) @(posedge clk);
		chk("abort_go", 32'h1, {29'h0, abort_go});
		tx_aborted <= 3'h1;
		@(posedge clk);
		tx_aborted <= 3'h0;
		rd(OFS_TXF);
		chk("txf", 32'h101, d & 32'h101);
		cpu_wait <= 1'b1;
		repeat (5) @(posedge clk);
		rd(OFS_STAT);
		chk("wait", 32'h4, d);
		cpu_wait <= 1'b0;
		// sleep must wait for the frame in progress
		mac_receiving <= 1'b1;
		wr(OFS_TXF, 32'h02);
		wr(OFS_CTRL0, 32'h6);
		repeat (20) @(posedge clk);
		rd(OFS_CTRL1);
		chk("slp_ack", 32'h0, d & 32'h2);
		mac_receiving <= 1'b0;
		repeat (10) @(posedge clk);
		rd(OFS_CTRL1);
		chk("slp_ack_tx", 32'h0, d & 32'h2);
		tx_sent <= 3'h2;
		@(posedge clk);
		tx_sent <= 3'h0;
		poll(OFS_CTRL1, 32'h2, 32'h2);
		chk("asleep", 32'h0, {30'h0, proto_run, busoff_count_en});
		node.dominant(30);
		rd(OFS_STAT);
		chk("glitch", 32'h10, d);
		node.dominant(150);
		poll(OFS_STAT, 32'hff, 32'h4);
		rd(OFS_CTRL0);
		chk("slp_req", 32'h0, d & 32'h2);
		bus_off <= 1'b0;
		rx_bg_full <= 1'b0;
		wr(OFS_CTRL0, 32'h20);
		cpu_wait <= 1'b1;
		repeat (10) @(posedge clk);
		chk("pd", 32'h3, {30'h0, proto_abort, bus_tx_pin});
		rd(OFS_STAT);
		chk("pd_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
		cpu_wait <= 1'b0;
		poll(OFS_STAT, 32'hff, 32'h4);
		cpu_stop <= 1'b1;
		repeat (10) @(posedge clk);
		rd(OFS_STAT);
		chk("stop_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
		cpu_stop <= 1'b0;
		poll(OFS_STAT, 32'hff, 32'h4);
		wr(OFS_BTIME, ~v);
		rd(OFS_BTIME);
		chk("btime_lock", {16'h0, v[15:0]}, d);
		special_mode <= 1'b1;
		wr(OFS_BTIME, ~v);
		rd(OFS_BTIME);
		chk("btime_special", {16'h0, ~v[15:0]}, d);
		wr(OFS_CTRL1, 32'h84);
		wr(OFS_TXF, 32'h04);
		mac_tx_bit <= 1'b0;
		repeat (2) @(posedge clk);
		chk("talk", 32'h2, {30'h0, tx_allow, bus_tx_pin});
		mac_tx_bit <= 1'b1;
		tx_sent <= 3'h4;
		@(posedge clk);
		tx_sent <= 3'h0;
		special_mode <= 1'b0;
		wr(OFS_CTRL0, 32'h1);
		rd(OFS_CTRL1);
		chk("iack_early", 32'h0, d & 32'h1);
		poll(OFS_CTRL1, 32'h1, 32'h1);
		rd(OFS_TXF);
		chk("txf_init", 32'h7, d);
		finish_test;
	end
endmodule : can_mode_power_control_test
bind cmp_mode_ctrl cmp_assertions chk_i (.clk, .rst_n, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .cpu_stop,
	.bus_tx_pin, .proto_abort, .proto_run, .tx_allow, .abort_go, .rx_fg_load,
	.busoff_count_en, .wake_event);
`default_nettype wire

// ---- verification/cmp_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module cmp_assertions
	import cmp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic cpu_stop,
	input wire logic bus_tx_pin,
	input wire logic proto_abort,
	input wire logic proto_run,
	input wire logic tx_allow,
	input wire logic [2:0] abort_go,
	input wire logic rx_fg_load,
	input wire logic busoff_count_en,
	input wire logic wake_event
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_held_tx_rec: assert property (
		proto_abort && $past(proto_abort) |-> bus_tx_pin)
		else $error("tx dominant while engine held");
	a_stop_power: assert property (
		cpu_stop [*6] |-> proto_abort && bus_tx_pin && !proto_run)
		else $error("stop did not power down");
	a_stop_no_reg: assert property (
		cpu_stop [*6] ##1 $rose(s_axi_rvalid) |-> s_axi_rresp == RESP_SLVERR)
		else $error("register read served in power down");
	a_read_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped early");
	a_write_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	a_abort_awake: assert property (
		|abort_go |-> proto_run || $past(proto_run))
		else $error("abort while asleep");
	a_busoff_awake: assert property (
		busoff_count_en |-> proto_run || $past(proto_run))
		else $error("bus-off count while asleep");
	a_load_awake: assert property (
		rx_fg_load |-> proto_run || $past(proto_run))
		else $error("receive load while asleep");
	a_tx_awake: assert property (
		tx_allow |-> proto_run || $past(proto_run))
		else $error("tx allowed while stopped");
	a_wake_pulse: assert property (
		wake_event |=> !wake_event)
		else $error("wake event longer than a cycle");
endmodule : cmp_assertions
`default_nettype wire

// ---- verification/cmp_bus_node.sv ----
`timescale 1ns/1ns
`default_nettype none
module cmp_bus_node
(
	input wire logic clk,
	input wire logic tx,
	output logic rx
);
	logic drv = 1'b1;
	// wired-and bus with pull-up: any dominant wins
	assign rx = tx & drv;
	task dominant(input int n);
		@(posedge clk);
		drv <= 1'b0;
		repeat (n) @(posedge clk);
		drv <= 1'b1;
	endtask : dominant
endmodule : cmp_bus_node
`default_nettype wire
